// File: hdl/mas_apb_regs.sv
`timescale 1ns/1ps
// apb slave holding the controller's own registers
module mas_apb_regs
   import mas_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // apb
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // register contents
   output logic [2:0] cmd_pulse_out,
   output logic enc_cmd_out,
   output logic [31:0] speed_out,
   output logic [31:0] enc_incr_out,
   output logic [31:0] enc_rev_out,
   input wire logic [31:0] status_in,
   input wire logic [31:0] last_sw_in
);
   logic wr;
   logic mapped;
   assign wr = psel_in && penable_in && pwrite_in;
   assign pready_out = 1'b1;
   assign mapped = (paddr_in <= REG_LAST_SW) && (paddr_in[1:0] == 2'b00);
   assign pslverr_out = psel_in && penable_in && !mapped;
   // command strobes, one cycle long
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cmd_pulse_out <= 3'h0;
         enc_cmd_out <= 1'b0;
      end else begin
         cmd_pulse_out <= (wr && paddr_in == REG_CTRL) ? pwdata_in[2:0] : 3'h0;
         enc_cmd_out <= wr && paddr_in == REG_CTRL && pwdata_in[CTRL_ENC];
      end
   end
   // parameter registers
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         speed_out <= 32'h00000000;
         enc_incr_out <= 32'h00000000;
         enc_rev_out <= 32'h00000000;
      end else if (wr) begin
         if (paddr_in == REG_SPEED) speed_out <= pwdata_in;
         if (paddr_in == REG_ENC_INCR) enc_incr_out <= pwdata_in;
         if (paddr_in == REG_ENC_REV) enc_rev_out <= pwdata_in;
      end
   end
   // read mux, zero for unmapped
   always_comb begin
      case (paddr_in)
         REG_STATUS: prdata_out = status_in;
         REG_SPEED: prdata_out = speed_out;
         REG_ENC_INCR: prdata_out = enc_incr_out;
         REG_ENC_REV: prdata_out = enc_rev_out;
         REG_LAST_SW: prdata_out = last_sw_in;
         default: prdata_out = 32'h00000000;
      endcase
   end
endmodule

// File: hdl/mas_obj_port.sv
`timescale 1ns/1ps
// single object access towards the drive, request held until ack
module mas_obj_port
   import mas_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // from sequencer
   input wire logic go_in,
   input wire logic wr_in,
   input wire logic [15:0] idx_in,
   input wire logic [7:0] sub_in,
   input wire logic [31:0] data_in,
   output logic done_out,
   output logic [31:0] rdata_out,
   // to drive
   output logic obj_req_out,
   output logic obj_wr_out,
   output logic [15:0] obj_idx_out,
   output logic [7:0] obj_sub_out,
   output logic [31:0] obj_wdata_out,
   input wire logic obj_ack_in,
   input wire logic [31:0] obj_rdata_in
);
   // request stays up until the drive acknowledges, however late
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         obj_req_out <= 1'b0;
         obj_wr_out <= 1'b0;
         obj_idx_out <= 16'h0000;
         obj_sub_out <= 8'h00;
         obj_wdata_out <= 32'h00000000;
         rdata_out <= 32'h00000000;
         done_out <= 1'b0;
      end else begin
         done_out <= 1'b0;
         if (obj_req_out && obj_ack_in) begin
            obj_req_out <= 1'b0;
            rdata_out <= obj_rdata_in;
            done_out <= 1'b1;
         end else if (go_in && !obj_req_out && !done_out) begin
            obj_req_out <= 1'b1;
            obj_wr_out <= wr_in;
            obj_idx_out <= idx_in;
            obj_sub_out <= sub_in;
            obj_wdata_out <= data_in;
         end
      end
   end
endmodule

// File: hdl/mas_setup_ctrl.sv
`timescale 1ns/1ps
module mas_setup_ctrl
   import mas_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // drive object port
   output logic obj_req_out,
   output logic obj_wr_out,
   output logic [15:0] obj_idx_out,
   output logic [7:0] obj_sub_out,
   output logic [31:0] obj_wdata_out,
   input wire logic obj_ack_in,
   input wire logic [31:0] obj_rdata_in,
   // status
   output logic busy_out,
   output logic restart_needed_out
);
   import mas_pkg::*;

   mas_state_t state;
   mas_state_t next_state;
   logic [2:0] cmd_pulse;
   logic enc_cmd;
   logic [31:0] speed;
   logic [31:0] enc_incr;
   logic [31:0] enc_rev;
   logic [31:0] status_word;
   logic [31:0] last_sw;
   logic go;
   logic op_wr;
   logic [15:0] op_idx;
   logic [7:0] op_sub;
   logic [31:0] op_data;
   logic op_done;
   logic [31:0] op_rdata;
   logic setup_done;
   logic index_found_flag;
   logic prog_busy_err;
   logic verify_err;

   // register file
   mas_apb_regs u_regs (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .psel_in(psel_in),
      .penable_in(penable_in),
      .pwrite_in(pwrite_in),
      .paddr_in(paddr_in),
      .pwdata_in(pwdata_in),
      .prdata_out(prdata_out),
      .pready_out(pready_out),
      .pslverr_out(pslverr_out),
      .cmd_pulse_out(cmd_pulse),
      .enc_cmd_out(enc_cmd),
      .speed_out(speed),
      .enc_incr_out(enc_incr),
      .enc_rev_out(enc_rev),
      .status_in(status_word),
      .last_sw_in(last_sw)
   );

   // object transfer engine
   mas_obj_port u_port (
      .mclk_in(mclk_in),
      .arst_n_in(arst_n_in),
      .go_in(go),
      .wr_in(op_wr),
      .idx_in(op_idx),
      .sub_in(op_sub),
      .data_in(op_data),
      .done_out(op_done),
      .rdata_out(op_rdata),
      .obj_req_out(obj_req_out),
      .obj_wr_out(obj_wr_out),
      .obj_idx_out(obj_idx_out),
      .obj_sub_out(obj_sub_out),
      .obj_wdata_out(obj_wdata_out),
      .obj_ack_in(obj_ack_in),
      .obj_rdata_in(obj_rdata_in)
   );

   // status register image
   assign status_word = {24'h000000, verify_err, prog_busy_err, restart_needed_out,
                         index_found_flag, setup_done, busy_out, 2'b00};
   assign busy_out = (state != MAS_IDLE) && (state != MAS_FAIL);

   // access selected by state
   always_comb begin
      go = busy_out;
      op_wr = 1'b1;
      op_idx = OBJ_CTRLWORD;
      op_sub = SUB_ZERO;
      op_data = 32'h00000000;
      case (state)
         MAS_CHK_PROG: begin
            op_wr = 1'b0;
            op_idx = OBJ_PROG_CTRL;
         end
         MAS_SET_MODE: begin
            op_idx = OBJ_MODE;
            op_data = MODE_AUTOSETUP;
         end
         MAS_CW_SHUT, MAS_V_SHUT, MAS_STOP: op_data = CW_SHUTDOWN;
         MAS_CW_ON, MAS_V_ON: op_data = CW_SWITCH_ON;
         MAS_CW_EN, MAS_V_EN: op_data = CW_ENABLE;
         MAS_CW_START: op_data = CW_ENABLE_START;
         MAS_POLL, MAS_VERIFY: begin
            op_wr = 1'b0;
            op_idx = OBJ_STATUSWORD;
         end
         MAS_SET_VMODE: begin
            op_idx = OBJ_MODE;
            op_data = MODE_VELOCITY;
         end
         MAS_SET_SPEED: begin
            op_idx = OBJ_TARGET_VEL;
            op_data = speed;
         end
         MAS_ENC_INCR: begin
            op_idx = OBJ_ENC_INCR;
            op_data = enc_incr;
         end
         MAS_ENC_REV: begin
            op_idx = OBJ_ENC_REV;
            op_data = enc_rev;
         end
         MAS_ENC_STORE: begin
            op_idx = OBJ_STORE;
            op_sub = SUB_TUNING;
            op_data = STORE_SIG;
         end
         default: go = busy_out;
      endcase
   end

   // sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         MAS_IDLE, MAS_FAIL: begin
            if (cmd_pulse[CTRL_AUTO]) next_state = MAS_CHK_PROG;
            else if (cmd_pulse[CTRL_VEL]) next_state = MAS_SET_VMODE;
            else if (cmd_pulse[CTRL_STOP]) next_state = MAS_STOP;
            else if (enc_cmd) next_state = MAS_ENC_INCR;
         end
         MAS_CHK_PROG: if (op_done) begin
            next_state = op_rdata[PROG_RUN_BIT] ? MAS_FAIL : MAS_SET_MODE;
         end
         MAS_SET_MODE: if (op_done) next_state = MAS_CW_SHUT;
         MAS_CW_SHUT: if (op_done) next_state = MAS_CW_ON;
         MAS_CW_ON: if (op_done) next_state = MAS_CW_EN;
         MAS_CW_EN: if (op_done) next_state = MAS_CW_START;
         MAS_CW_START: if (op_done) next_state = MAS_POLL;
         MAS_POLL: if (op_done && op_rdata[DONE_BIT]) next_state = MAS_IDLE;
         MAS_SET_VMODE: if (op_done) next_state = MAS_VERIFY;
         MAS_VERIFY: if (op_done) next_state = MAS_SET_SPEED;
         MAS_SET_SPEED: if (op_done) next_state = MAS_V_SHUT;
         MAS_V_SHUT: if (op_done) next_state = MAS_V_ON;
         MAS_V_ON: if (op_done) next_state = MAS_V_EN;
         MAS_V_EN: if (op_done) next_state = MAS_IDLE;
         MAS_STOP: if (op_done) next_state = MAS_IDLE;
         MAS_ENC_INCR: if (op_done) next_state = MAS_ENC_REV;
         MAS_ENC_REV: if (op_done) next_state = MAS_ENC_STORE;
         MAS_ENC_STORE: if (op_done) next_state = MAS_IDLE;
         default: next_state = MAS_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) state <= MAS_IDLE;
      else state <= next_state;
   end

   // auto setup results
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         setup_done <= 1'b0;
         index_found_flag <= 1'b0;
         restart_needed_out <= 1'b0;
      end else begin
         if (state == MAS_CHK_PROG) begin
            setup_done <= 1'b0;
         end
         if (state == MAS_POLL && op_done && op_rdata[DONE_BIT]) begin
            setup_done <= 1'b1;
            index_found_flag <= op_rdata[INDEX_BIT];
            restart_needed_out <= 1'b1;
         end
      end
   end

   // error flags and last statusword
   always_ff @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prog_busy_err <= 1'b0;
         verify_err <= 1'b0;
         last_sw <= STATUS_RST;
      end else begin
         if (state == MAS_CHK_PROG && op_done) prog_busy_err <= op_rdata[PROG_RUN_BIT];
         if ((state == MAS_POLL || state == MAS_VERIFY) && op_done) last_sw <= op_rdata;
         if (state == MAS_VERIFY && op_done) verify_err <= 1'b0;
      end
   end

   // sequencing checks
   a_start_after_enable: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state == MAS_CW_START |-> $past(state) inside {MAS_CW_EN, MAS_CW_START})
      else $error("start issued before enable");
   a_prog_block: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state == MAS_CHK_PROG && op_done && op_rdata[0] |=> state == MAS_FAIL)
      else $error("start despite running program");
   a_done_flag: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state == MAS_POLL && op_done && op_rdata[12] |=> setup_done && state == MAS_IDLE)
      else $error("completion not taken");
   a_index_copy: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state == MAS_POLL && op_done && op_rdata[12] |=> index_found_flag == $past(op_rdata[10]))
      else $error("index flag wrong");
   a_restart_flag: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      $rose(setup_done) |-> restart_needed_out)
      else $error("restart not flagged");
   a_mode_value: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      obj_req_out && obj_idx_out == 16'h6060 |-> obj_wdata_out inside {32'hFFFFFFFE, 32'h2})
      else $error("bad mode value");
   sequence s_speed_done;
      state == MAS_SET_SPEED && op_done;
   endsequence
   a_speed_first: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      s_speed_done |=> state == MAS_V_SHUT ##[1:1000] state != MAS_V_SHUT)
      else $error("speed not before enable");
   a_stop_value: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state == MAS_STOP && obj_req_out |-> obj_wdata_out == 32'h6)
      else $error("stop value wrong");
   a_req_hold: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      obj_req_out && !obj_ack_in |=> obj_req_out && $stable(obj_idx_out))
      else $error("request dropped");
   a_tuning_store: assert property (@(posedge mclk_in) disable iff (!arst_n_in)
      state == MAS_ENC_STORE && obj_req_out |-> obj_sub_out == 8'h06)
      else $error("store category wrong");
endmodule

// File: pkg/mas_pkg.sv
package mas_pkg;
   // object indices; the feedback ones are not used by the sequencer
   localparam logic [15:0] OBJ_PROG_CTRL = 16'h2300;
   localparam logic [15:0] OBJ_FB_ASSIGN = 16'h3203;
   localparam logic [15:0] OBJ_CTRLWORD = 16'h6040;
   localparam logic [15:0] OBJ_STATUSWORD = 16'h6041;
   localparam logic [15:0] OBJ_TARGET_VEL = 16'h6042;
   localparam logic [15:0] OBJ_MODE = 16'h6060;
   localparam logic [15:0] OBJ_ENC_INCR = 16'h60E6;
   localparam logic [15:0] OBJ_ENC_REV = 16'h60EB;
   localparam logic [15:0] OBJ_STORE = 16'h1010;
   localparam logic [15:0] OBJ_FB_SENSORLESS = 16'h3380;
   localparam logic [15:0] OBJ_FB_HALL = 16'h3390;
   localparam logic [15:0] OBJ_FB_ENC1 = 16'h33A0;
   // object values
   localparam logic [31:0] MODE_AUTOSETUP = 32'hFFFFFFFE;
   localparam logic [31:0] MODE_VELOCITY = 32'h00000002;
   localparam logic [31:0] CW_SHUTDOWN = 32'h00000006;
   localparam logic [31:0] CW_SWITCH_ON = 32'h00000007;
   localparam logic [31:0] CW_ENABLE = 32'h0000000F;
   localparam logic [31:0] CW_ENABLE_START = 32'h0000001F;
   localparam logic [31:0] STORE_SIG = 32'h65766173;
   localparam logic [7:0] SUB_ZERO = 8'h00;
   localparam logic [7:0] SUB_TUNING = 8'h06;
   // statusword / program control bit positions
   localparam int MODE_SPEC_BIT = 4;
   localparam int DONE_BIT = 12;
   localparam int INDEX_BIT = 10;
   localparam int PROG_RUN_BIT = 0;
   // apb register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_SPEED = 8'h08;
   localparam logic [7:0] REG_ENC_INCR = 8'h0C;
   localparam logic [7:0] REG_ENC_REV = 8'h10;
   localparam logic [7:0] REG_LAST_SW = 8'h14;
   // ctrl register bits
   localparam int CTRL_AUTO = 0;
   localparam int CTRL_VEL = 1;
   localparam int CTRL_STOP = 2;
   localparam int CTRL_ENC = 3;
   localparam logic [31:0] STATUS_RST = 32'h00000000;
   // sequencer states
   typedef enum logic [4:0] {
      MAS_IDLE = 5'b00000,
      MAS_CHK_PROG = 5'b00001,
      MAS_SET_MODE = 5'b00010,
      MAS_CW_SHUT = 5'b00011,
      MAS_CW_ON = 5'b00100,
      MAS_CW_EN = 5'b00101,
      MAS_CW_START = 5'b00110,
      MAS_POLL = 5'b00111,
      MAS_VERIFY = 5'b01000,
      MAS_SET_VMODE = 5'b01001,
      MAS_SET_SPEED = 5'b01010,
      MAS_V_SHUT = 5'b01011,
      MAS_V_ON = 5'b01100,
      MAS_V_EN = 5'b01101,
      MAS_STOP = 5'b01110,
      MAS_ENC_INCR = 5'b01111,
      MAS_ENC_REV = 5'b10000,
      MAS_ENC_STORE = 5'b10001,
      MAS_FAIL = 5'b10010
   } mas_state_t;
endpackage

// File: sim/mas_drive_model.sv
`timescale 1ns/1ps
// behavioural drive: object dictionary, power state and identification run
module mas_drive_model
   import mas_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // object port
   input wire logic obj_req_in,
   input wire logic obj_wr_in,
   input wire logic [15:0] obj_idx_in,
   input wire logic [7:0] obj_sub_in,
   input wire logic [31:0] obj_wdata_in,
   output logic obj_ack_out,
   output logic [31:0] obj_rdata_out,
   // scenario controls and observation
   input wire logic prog_run_in,
   input wire logic has_index_in,
   output logic running_out,
   output logic moving_out
);
   logic [31:0] od [logic [23:0]];
   logic [31:0] mode;
   logic [31:0] cw;
   logic done;
   logic found;
   logic [3:0] polls;
   int wt;
   // one access at a time, answered after a random delay
   always @(posedge mclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         obj_ack_out <= 1'b0;
         obj_rdata_out <= 32'h0;
         running_out <= 1'b0;
         moving_out <= 1'b0;
         mode <= 32'h0;
         cw <= 32'h0;
         done <= 1'b0;
         found <= 1'b0;
         polls <= 4'h0;
         wt <= 0;
      end else begin
         obj_ack_out <= 1'b0;
         obj_rdata_out <= ~obj_rdata_out; // data line not held outside an answer
         if (obj_req_in && !obj_ack_out && wt != 0) begin
            wt <= wt - 1;
         end else if (obj_req_in && !obj_ack_out) begin
            obj_ack_out <= 1'b1;
            // identification eats the cpu, so answers come late
            wt <= running_out ? 5 + $urandom % 20 : $urandom % 3;
            if (obj_wr_in) begin
               od[{obj_idx_in, obj_sub_in}] = obj_wdata_in;
               if (obj_idx_in == OBJ_MODE) mode <= obj_wdata_in;
               if (obj_idx_in == OBJ_CTRLWORD) begin
                  cw <= obj_wdata_in;
                  // start only in auto setup mode out of operation enabled
                  if (mode == MODE_AUTOSETUP && cw == CW_ENABLE &&
                      obj_wdata_in == CW_ENABLE_START) begin
                     running_out <= 1'b1;
                     done <= 1'b0;
                     polls <= 4'h3;
                  end
                  if (mode == MODE_VELOCITY && obj_wdata_in == CW_ENABLE) moving_out <= 1'b1;
                  if (obj_wdata_in == CW_SHUTDOWN) moving_out <= 1'b0;
               end
            end else if (obj_idx_in == OBJ_PROG_CTRL) begin
               obj_rdata_out <= {31'h0, prog_run_in};
            end else if (obj_idx_in == OBJ_STATUSWORD) begin
               obj_rdata_out <= {19'h0, done, 1'b0, found, 10'h027};
               // end of the measurement passes; done and index found latched
               if (running_out && polls == 4'h0) begin
                  running_out <= 1'b0;
                  done <= 1'b1;
                  found <= has_index_in;
               end else if (running_out) begin
                  polls <= polls - 4'h1;
               end
            end else begin
               obj_rdata_out <= od.exists({obj_idx_in, obj_sub_in}) ?
                  od[{obj_idx_in, obj_sub_in}] : 32'h0;
            end
         end
      end
   end
endmodule

// File: sim/motor_auto_setup_sequencer_tb.sv
`timescale 1ns/1ps
// self-checking bench for the auto setup sequencer
module motor_auto_setup_sequencer_tb;
   import mas_pkg::*;
   logic mclk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic psel_in = 1'b0;
   logic penable_in = 1'b0;
   logic pwrite_in = 1'b0;
   logic [7:0] paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0;
   logic [31:0] prdata_out;
   logic pready_out;
   logic pslverr_out;
   logic obj_req_out;
   logic obj_wr_out;
   logic [15:0] obj_idx_out;
   logic [7:0] obj_sub_out;
   logic [31:0] obj_wdata_out;
   logic obj_ack_in;
   logic [31:0] obj_rdata_in;
   logic busy_out;
   logic restart_needed_out;
   logic prog_run_in = 1'b0;
   logic has_index_in = 1'b0;
   logic running;
   logic moving;
   logic [32:0] apb_q [$];
   logic [56:0] obj_q [$];
   logic [56:0] obj_seen;
   logic [31:0] seed_v;
   logic [31:0] rnd_a;
   logic [31:0] rnd_b;
   int fails = 0;
   int comparisons = 0;

   mas_setup_ctrl i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .obj_req_out(obj_req_out), .obj_wr_out(obj_wr_out),
      .obj_idx_out(obj_idx_out), .obj_sub_out(obj_sub_out), .obj_wdata_out(obj_wdata_out),
      .obj_ack_in(obj_ack_in), .obj_rdata_in(obj_rdata_in), .busy_out(busy_out),
      .restart_needed_out(restart_needed_out));
   mas_drive_model i_drive (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
      .obj_req_in(obj_req_out), .obj_wr_in(obj_wr_out), .obj_idx_in(obj_idx_out),
      .obj_sub_in(obj_sub_out), .obj_wdata_in(obj_wdata_out), .obj_ack_out(obj_ack_in),
      .obj_rdata_out(obj_rdata_in), .prog_run_in(prog_run_in), .has_index_in(has_index_in),
      .running_out(running), .moving_out(moving));

   // 100 MHz clock
   always #5 mclk_in = ~mclk_in;

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("counts: comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // one apb transfer; a read notes {pslverr, prdata} expected
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      @(posedge mclk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      if (!w) apb_q.push_back(e);
      @(posedge mclk_in);
      penable_in <= 1'b1;
      @(posedge mclk_in);
      while (pready_out !== 1'b1) @(posedge mclk_in);
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   task automatic obj_exp(input logic w, input logic [15:0] i, input logic [7:0] s,
                          input logic [31:0] d);
      obj_q.push_back({w, i, s, d});
   endtask

   // wait for the sequence to end; every noted drive access must have come
   task automatic wait_idle();
      repeat (4) @(posedge mclk_in);
      for (int n = 0; n < 3000 && busy_out !== 1'b0; n++) @(posedge mclk_in);
      check(busy_out, 1'b0);
      check(obj_q.size(), 0);
   endtask

   // apb read data against the oldest note
   always @(posedge mclk_in) begin
      if (psel_in && penable_in && pready_out && !pwrite_in) begin
         if (apb_q.size() > 0) check({pslverr_out, prdata_out}, apb_q.pop_front());
         else check(64'h0, 64'h1);
      end
   end

   // drive accesses against the oldest note; status polls are not counted
   always @(posedge mclk_in) begin
      if (obj_req_out && obj_ack_in && !(!obj_wr_out && obj_idx_out == OBJ_STATUSWORD)) begin
         obj_seen = {obj_wr_out, obj_idx_out, obj_sub_out, obj_wr_out ? obj_wdata_out : 32'h0};
         if (obj_q.size() > 0) check(obj_seen, obj_q.pop_front());
         else check(obj_seen, 64'h0);
      end
   end

   // watchdog
   initial begin
      #300000;
      fails++;
      end_of_test();
   end

   initial begin
      seed_v = $urandom(78);
      repeat (12) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      apb(1'b0, REG_STATUS, 32'h0, {1'b0, STATUS_RST});
      apb(1'b0, 8'h18, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 8'h1C, 32'hFFFFFFFF, '0);
      apb(1'b0, 8'h02, 32'h0, {1'b1, 32'h0});
      $display("test reset and unmapped done");
      prog_run_in <= 1'b1;
      obj_exp(1'b0, OBJ_PROG_CTRL, SUB_ZERO, 32'h0);
      apb(1'b1, REG_CTRL, 32'h1, '0);
      wait_idle();
      apb(1'b0, REG_STATUS, 32'h0, {1'b0, 32'h40});
      $display("test program running done");
      prog_run_in <= 1'b0;
      for (int k = 1; k >= 0; k--) begin
         has_index_in <= k[0];
         obj_exp(1'b0, OBJ_PROG_CTRL, SUB_ZERO, 32'h0);
         obj_exp(1'b1, OBJ_MODE, SUB_ZERO, MODE_AUTOSETUP);
         obj_exp(1'b1, OBJ_CTRLWORD, SUB_ZERO, CW_SHUTDOWN);
         obj_exp(1'b1, OBJ_CTRLWORD, SUB_ZERO, CW_SWITCH_ON);
         obj_exp(1'b1, OBJ_CTRLWORD, SUB_ZERO, CW_ENABLE);
         obj_exp(1'b1, OBJ_CTRLWORD, SUB_ZERO, CW_ENABLE_START);
         apb(1'b1, REG_CTRL, 32'h1, '0);
         for (int n = 0; n < 500 && running !== 1'b1; n++) @(posedge mclk_in);
         check(running, 1'b1);
         apb(1'b1, REG_CTRL, 32'h4, '0);
         // index flag of the previous run stands until this run ends
         apb(1'b0, REG_STATUS, 32'h0, {1'b0, k ? 32'h4 : 32'h34});
         wait_idle();
         apb(1'b0, REG_STATUS, 32'h0, {1'b0, k ? 32'h38 : 32'h28});
         apb(1'b0, REG_LAST_SW, 32'h0, {1'b0, k ? 32'h1427 : 32'h1027});
         check(restart_needed_out, 1'b1);
         $display("test auto setup done");
      end
      rnd_a = $urandom;
      obj_exp(1'b1, OBJ_MODE, SUB_ZERO, MODE_VELOCITY);
      obj_exp(1'b1, OBJ_TARGET_VEL, SUB_ZERO, rnd_a);
      obj_exp(1'b1, OBJ_CTRLWORD, SUB_ZERO, CW_SHUTDOWN);
      obj_exp(1'b1, OBJ_CTRLWORD, SUB_ZERO, CW_SWITCH_ON);
      obj_exp(1'b1, OBJ_CTRLWORD, SUB_ZERO, CW_ENABLE);
      apb(1'b1, REG_SPEED, rnd_a, '0);
      apb(1'b0, REG_SPEED, 32'h0, {1'b0, rnd_a});
      apb(1'b1, REG_CTRL, 32'h2, '0);
      wait_idle();
      check(moving, 1'b1);
      obj_exp(1'b1, OBJ_CTRLWORD, SUB_ZERO, CW_SHUTDOWN);
      apb(1'b1, REG_CTRL, 32'h4, '0);
      wait_idle();
      check(moving, 1'b0);
      $display("test velocity run done");
      rnd_a = $urandom;
      rnd_b = $urandom;
      obj_exp(1'b1, OBJ_ENC_INCR, SUB_ZERO, rnd_a);
      obj_exp(1'b1, OBJ_ENC_REV, SUB_ZERO, rnd_b);
      obj_exp(1'b1, OBJ_STORE, SUB_TUNING, STORE_SIG);
      apb(1'b1, REG_ENC_INCR, rnd_a, '0);
      apb(1'b1, REG_ENC_REV, rnd_b, '0);
      apb(1'b0, REG_ENC_REV, 32'h0, {1'b0, rnd_b});
      apb(1'b1, REG_CTRL, 32'h8, '0);
      wait_idle();
      $display("test encoder resolution done");
      arst_n_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      apb(1'b0, REG_STATUS, 32'h0, {1'b0, STATUS_RST});
      check(restart_needed_out, 1'b0);
      $display("test second reset done");
      end_of_test();
   end
endmodule
